// [verilog/css_sequencer.sv]
// Column sampling sequencer: shift timing, cascade, bank and mux select
// Summary of operation
// - Right shift: right pin in, left pin out
// - Left shift: left pin in, right pin out
// - Start pulse taken on phase 1 only
// - Successive: pulses on all three phases
// - Simultaneous: pulses on phase 1 only
// - Stripe simultaneous, delta and mosaic successive
// - Two banks alternate sampling and holding
// - Strobe fall advances mux, swaps bank
// - Reset clears counter, bank, disables mux
// - No sampling before first strobe
// - Select pins decode the four arrays
// - Direction high scans first to last
// - Stripe passes video through on right shift, reversed on left shift, fixed rotation
`timescale 1ns/1ps
`include "css_consts.svh"
module css_sequencer (
	input wire logic mclk,
	input wire logic rst,
	input wire css_pkg::css_phase_t phaseClk,
	input wire logic lineSelectStrobe,
	input wire logic arraySelectA,
	input wire logic arraySelectB,
	input wire logic scanDir,
	input wire logic rightCascadeIn,
	output logic rightCascadeOut,
	output logic rightCascadeOe,
	input wire logic leftCascadeIn,
	output logic leftCascadeOut,
	output logic leftCascadeOe,
	input wire css_pkg::css_video_t videoIn,
	input wire logic videoValid,
	output logic videoReady,
	output css_pkg::css_sample_evt_t sampleEvt,
	output logic bankSel,
	output logic muxEnabled,
	output logic [1:0] muxCount
);
	import css_pkg::*;

	function automatic logic [1:0] chanOf(input logic [7:0] pos, input logic [1:0] rot,
		input logic right);
		logic [8:0] s;
		logic [1:0] m;
		s = {1'b0, pos} + {7'h00, rot};
		m = 2'(s % 9'h003);
		chanOf = right ? m : 2'(({1'b0, `CSS_MUX_LAST} - {1'b0, 2'(pos % 8'h03)}
			+ {1'b0, rot}) % 3'h3);
	endfunction : chanOf

	function automatic logic [7:0] pickChan(input css_video_t v, input logic [1:0] ch);
		case (ch)
			2'h0: pickChan = v.c1;
			2'h1: pickChan = v.c2;
			default: pickChan = v.c3;
		endcase
	endfunction : pickChan

	function automatic logic [7:0] physCol(input logic [7:0] pos, input logic right);
		physCol = right ? pos : 8'(`CSS_LAST_COL - pos);
	endfunction : physCol

	// Two-flop synchronisers, third stage only for edge detection
	logic [8:0] pinRaw;
	logic [8:0] pinMeta;
	logic [8:0] pinSync;
	logic [8:0] pinPrev;
	assign pinRaw = {phaseClk.ph3, phaseClk.ph2, phaseClk.ph1, arraySelectB, arraySelectA,
		scanDir, lineSelectStrobe, leftCascadeIn, rightCascadeIn};
	always_ff @(posedge mclk) begin
		if (rst) begin
			pinMeta <= 9'h000;
			pinSync <= 9'h000;
			pinPrev <= 9'h000;
		end else begin
			pinMeta <= pinRaw;
			pinSync <= pinMeta;
			pinPrev <= pinSync;
		end
	end

	wire dirRight = pinSync[`CSS_PIN_DIR];
	wire ph1Rise = pinSync[`CSS_PIN_PH1] && !pinPrev[`CSS_PIN_PH1];
	wire ph2Rise = pinSync[`CSS_PIN_PH2] && !pinPrev[`CSS_PIN_PH2];
	wire ph3Rise = pinSync[`CSS_PIN_PH3] && !pinPrev[`CSS_PIN_PH3];
	wire strobeFall = !pinSync[`CSS_PIN_STROBE] && pinPrev[`CSS_PIN_STROBE];
	wire cascIn = dirRight ? pinSync[`CSS_PIN_RIGHT] : pinSync[`CSS_PIN_LEFT];

	css_mode_t mode;
	assign mode = css_mode_t'({pinSync[`CSS_PIN_SELA], pinSync[`CSS_PIN_SELB]});
	wire simul = (mode == MODE_STRIPE);
	wire [1:0] rot = simul ? `CSS_MUX_ZERO :
		(mode == MODE_DELTA_SINGLE) ? {1'b0, muxCount[0]} : muxCount;

	css_state_t state;
	css_state_t next_state;
	logic [7:0] pos;
	logic [7:0] next_pos;
	logic cascOut;

	// Successive steps one column per phase edge, simultaneous three per phase 1
	wire stepEdge = simul ? ph1Rise : (ph1Rise || ph2Rise || ph3Rise);
	wire startSeen = (state == ST_IDLE) && ph1Rise && cascIn && muxEnabled;
	wire fire = (state == ST_RUN) && stepEdge;
	wire lastStep = simul ? (pos >= `CSS_GROUP_LAST) : (pos == `CSS_LAST_COL);
	wire [7:0] stepSize = simul ? `CSS_STEP_GROUP : `CSS_STEP_ONE;

	always_comb begin
		next_state = state;
		next_pos = pos;
		case (state)
			ST_IDLE: begin
				if (startSeen) begin
					next_state = ST_RUN;
					next_pos = `CSS_POS_ZERO;
				end
			end
			ST_RUN: begin
				if (fire) begin
					next_pos = 8'(pos + stepSize);
					if (lastStep) begin
						next_state = ST_IDLE;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			pos <= `CSS_POS_ZERO;
		end else begin
			state <= next_state;
			pos <= next_pos;
		end
	end

	// Held until the next phase 1 so a slower neighbour still sees it
	always_ff @(posedge mclk) begin
		if (rst) begin
			cascOut <= 1'b0;
		end else if (fire && lastStep) begin
			cascOut <= 1'b1;
		end else if (ph1Rise) begin
			cascOut <= 1'b0;
		end
	end
	assign leftCascadeOut = dirRight && cascOut;
	assign leftCascadeOe = dirRight;
	assign rightCascadeOut = !dirRight && cascOut;
	assign rightCascadeOe = !dirRight;

	// Mux select, bank swap and the armed flag cleared by reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			muxCount <= `CSS_MUX_ZERO;
			bankSel <= 1'b0;
			muxEnabled <= 1'b0;
		end else if (strobeFall) begin
			muxCount <= (muxCount == `CSS_MUX_LAST) ? `CSS_MUX_ZERO : 2'(muxCount + 1'b1);
			bankSel <= !bankSel;
			muxEnabled <= 1'b1;
		end
	end

	// Video words wait here; an empty FIFO still lets the column pulse go
	css_video_t fifoData;
	logic fifoValid;
	css_fifo #(
		.WIDTH(`CSS_FIFO_WIDTH),
		.DEPTH(`CSS_FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst(rst),
		.inValid(videoValid),
		.inReady(videoReady),
		.inData(videoIn),
		.outValid(fifoValid),
		.outReady(fire),
		.outData(fifoData)
	);

	wire [7:0] pos1 = 8'(pos + `CSS_STEP_ONE);
	wire [7:0] pos2 = 8'(pos + 8'h02);
	css_video_t laneData;
	assign laneData.c1 = pickChan(fifoData, chanOf(pos, rot, dirRight));
	assign laneData.c2 = simul ? pickChan(fifoData, chanOf(pos1, rot, dirRight)) : 8'h00;
	assign laneData.c3 = simul ? pickChan(fifoData, chanOf(pos2, rot, dirRight)) : 8'h00;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sampleEvt <= '0;
		end else begin
			sampleEvt.valid <= fire;
			sampleEvt.simul <= simul;
			sampleEvt.bank <= bankSel;
			sampleEvt.dataValid <= fire && fifoValid;
			sampleEvt.column <= physCol(pos, dirRight);
			sampleEvt.data <= fifoValid ? laneData : '0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_start_phase_one: assert property ($rose(state == ST_RUN) |-> $past(ph1Rise))
		else $error("Start taken without phase 1 edge");
	a_no_sample_unarmed: assert property (!muxEnabled |=> !sampleEvt.valid)
		else $error("Sampling before first strobe");
	a_simul_phase_one: assert property (sampleEvt.valid && sampleEvt.simul
		|-> $past(ph1Rise)) else $error("Simultaneous pulse off phase 1");
	a_succ_any_phase: assert property (sampleEvt.valid && !sampleEvt.simul
		|-> $past(ph1Rise || ph2Rise || ph3Rise)) else $error("Successive pulse no edge");
	a_mode_style: assert property (sampleEvt.valid |-> sampleEvt.simul == $past(mode == MODE_STRIPE))
		else $error("Sampling style does not follow array");
	a_bank_swap: assert property (strobeFall |=> bankSel != $past(bankSel)
		&& muxEnabled) else $error("Strobe did not swap bank");
	a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0) rst |=> muxCount == `CSS_MUX_ZERO
		&& !bankSel && !muxEnabled) else $error("Reset did not clear select");
	a_casc_right: assert property (dirRight |-> leftCascadeOe && !rightCascadeOe
		&& !rightCascadeOut) else $error("Right shift pin roles wrong");
	a_casc_left: assert property (!dirRight |-> rightCascadeOe && !leftCascadeOe
		&& !leftCascadeOut) else $error("Left shift pin roles wrong");
	a_casc_after_last: assert property ($rose(cascOut) |-> $past(fire && lastStep)
		&& $past(state) == ST_RUN) else $error("Cascade out before last column");
	a_scan_first_col: assert property (sampleEvt.valid && $past(pos == `CSS_POS_ZERO)
		|-> sampleEvt.column == ($past(dirRight) ? `CSS_POS_ZERO : `CSS_LAST_COL))
		else $error("Scan does not start at direction end");
	a_stripe_through: assert property (sampleEvt.dataValid && sampleEvt.simul
		&& $past(dirRight) && $past(pos % 8'h03 == `CSS_POS_ZERO)
		|-> sampleEvt.data == $past(fifoData)) else $error("Stripe not passed through");

	c_start_run: cover property ($rose(state == ST_RUN));
	c_cascade_out: cover property ($rose(cascOut));
	c_left_event: cover property (sampleEvt.valid && !$past(dirRight));
	c_fifo_full: cover property (!videoReady);
endmodule : css_sequencer

// [verilog/css_consts.svh]
// Constants for the column sampling sequencer
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
`define CSS_LAST_COL 8'hEF
`define CSS_POS_ZERO 8'h00
`define CSS_STEP_ONE 8'h01
`define CSS_STEP_GROUP 8'h03
`define CSS_GROUP_LAST 8'hED
`define CSS_MUX_ZERO 2'h0
`define CSS_MUX_LAST 2'h2
`define CSS_FIFO_WIDTH 24
`define CSS_FIFO_DEPTH 16
`define CSS_PIN_RIGHT 0
`define CSS_PIN_LEFT 1
`define CSS_PIN_STROBE 2
`define CSS_PIN_DIR 3
`define CSS_PIN_SELA 4
`define CSS_PIN_SELB 5
`define CSS_PIN_PH1 6
`define CSS_PIN_PH2 7
`define CSS_PIN_PH3 8
`endif

// [verilog/css_pkg.sv]
// Types for the column sampling sequencer
package css_pkg;
	typedef enum logic [1:0] {
		MODE_STRIPE = 2'h0,
		MODE_DELTA_SINGLE = 2'h1,
		MODE_MOSAIC = 2'h2,
		MODE_DELTA_DOUBLE = 2'h3
	} css_mode_t;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} css_state_t;
	typedef struct packed {
		logic ph3;
		logic ph2;
		logic ph1;
	} css_phase_t;
	typedef struct packed {
		logic [7:0] c3;
		logic [7:0] c2;
		logic [7:0] c1;
	} css_video_t;
	typedef struct packed {
		logic valid;
		logic simul;
		logic bank;
		logic dataValid;
		logic [7:0] column;
		css_video_t data;
	} css_sample_evt_t;
endpackage : css_pkg

// [verilog/css_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module css_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;
	assign inReady = (count != DEPTH[AW:0]);
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			wrPtr <= push ? AW'(wrPtr + 1'b1) : wrPtr;
			rdPtr <= pop ? AW'(rdPtr + 1'b1) : rdPtr;
			count <= (AW+1)'(count + push - pop);
		end
	end
	a_fifo_no_over: assert property (@(posedge clk) disable iff (rst)
		count <= DEPTH) else $error("FIFO count above depth");
endmodule : css_fifo

// [dv/css_ctrl_model.sv]
// Timing controller model: phase clocks, start pulse and line strobe
`timescale 1ns/1ps
module css_ctrl_model (
	input wire logic mclk,
	input wire logic dir,
	output css_pkg::css_phase_t phase,
	output logic strobe,
	output logic startRight,
	output logic startLeft
);
	import css_pkg::*;
	logic start;
	assign startRight = dir & start;
	assign startLeft = ~dir & start;
	initial begin
		phase = '0;
		strobe = 1'b0;
		start = 1'b0;
	end
	// One strobe per line, sent before video
	task automatic strobe_pulse();
		@(negedge mclk);
		strobe = 1'b1;
		repeat (4) @(negedge mclk);
		strobe = 1'b0;
		repeat (6) @(negedge mclk);
	endtask : strobe_pulse
	// Phases rotate one-hot, 7 cycles each, so edges survive the synchroniser
	task automatic run_line(input int startPh);
		for (int k = 0; k < 244; k++) begin
			@(negedge mclk);
			start = (k == startPh);
			repeat (3) @(negedge mclk);
			phase = css_phase_t'(3'h1 << (k % 3));
			repeat (3) @(negedge mclk);
		end
		phase = '0;
		start = 1'b0;
	endtask : run_line
endmodule : css_ctrl_model

// [dv/tb_top.sv]
// Self-checking bench for the column sampling sequencer
`timescale 1ns/1ps
module tb_top;
	import css_pkg::*;
	logic mclk, rst, scanDir, selA, selB, videoValid, ctlR, ctlL, strobe, took;
	logic rightOut, rightOe, leftOut, leftOe, bankSel, muxEnabled, videoReady;
	logic [1:0] muxCount;
	logic [7:0] firstCol, lastCol;
	css_phase_t phase;
	css_video_t videoIn, w;
	css_sample_evt_t evt;
	css_video_t q[$];
	int n_mismatch = 0;
	int compares = 0;
	int evCount, outAt, mode, nStrobe;
	wire rightPin = rightOe ? rightOut : ctlR;
	wire leftPin = leftOe ? leftOut : ctlL;
	css_sequencer dut (.mclk(mclk), .rst(rst), .phaseClk(phase), .lineSelectStrobe(strobe),
		.arraySelectA(selA), .arraySelectB(selB), .scanDir(scanDir), .rightCascadeIn(rightPin),
		.rightCascadeOut(rightOut), .rightCascadeOe(rightOe), .leftCascadeIn(leftPin),
		.leftCascadeOut(leftOut), .leftCascadeOe(leftOe), .videoIn(videoIn),
		.videoValid(videoValid), .videoReady(videoReady), .sampleEvt(evt), .bankSel(bankSel),
		.muxEnabled(muxEnabled), .muxCount(muxCount));
	css_ctrl_model ctl (.mclk(mclk), .dir(scanDir), .phase(phase), .strobe(strobe),
		.startRight(ctlR), .startLeft(ctlL));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	function automatic logic [7:0] exp_last(input int m, input logic dir);
		if (m == 0) return dir ? 8'hED : 8'h02;
		return dir ? 8'hEF : 8'h00;
	endfunction : exp_last
	// Words are held until taken; the queue mirrors the FIFO
	always @(negedge mclk) begin
		if (!videoValid || took) begin
			videoValid = ($urandom % 4) != 0;
			videoIn = 24'($urandom);
		end
	end
	always @(posedge mclk) begin
		took = videoValid && videoReady && !rst;
		if (took) q.push_back(videoIn);
		if (rst) q.delete();
		if (evt.valid === 1'b1 && !rst) begin
			if (evCount == 0) firstCol = evt.column;
			lastCol = evt.column;
			evCount++;
			check("evt.simul", mode == 0, evt.simul);
			check("evt.bank", nStrobe % 2, evt.bank);
			if (evt.dataValid === 1'b1 && q.size() > 0) begin
				w = q.pop_front();
				if (mode == 0) check("evt.data", scanDir ? w : {w.c1, w.c2, w.c3}, evt.data);
			end else if (evt.dataValid !== 1'b1) check("idle data", 0, evt.data);
		end
		if ((scanDir ? leftOut & leftOe : rightOut & rightOe) && outAt < 0) outAt = evCount;
	end
	task automatic do_reset();
		@(negedge mclk);
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		nStrobe = 0;
		check("bankSel", 0, bankSel);
		check("muxCount", 0, muxCount);
		check("muxEnabled", 0, muxEnabled);
	endtask : do_reset
	task automatic line_strobe();
		ctl.strobe_pulse();
		nStrobe++;
		check("bankSel", nStrobe % 2, bankSel);
		check("muxCount", nStrobe % 3, muxCount);
		check("muxEnabled", 1, muxEnabled);
	endtask : line_strobe
	task automatic do_line(input int m, input logic dir, input int startPh, input int expN);
		@(negedge mclk);
		mode = m;
		{selA, selB} = m[1:0];
		scanDir = dir;
		evCount = 0;
		outAt = -1;
		repeat (6) @(negedge mclk);
		ctl.run_line(startPh);
		repeat (8) @(negedge mclk);
		check("event count", expN, evCount);
		check("cascade out at", expN > 0 ? expN : -1, outAt);
		check("in pin oe", 0, dir ? rightOe : leftOe);
		if (expN > 0) begin
			check("first column", dir ? 8'h00 : 8'hEF, firstCol);
			check("last column", exp_last(m, dir), lastCol);
		end
	endtask : do_line
	initial begin
		rst = 1'b1;
		scanDir = 1'b1;
		selA = 1'b0;
		selB = 1'b0;
		videoValid = 1'b0;
		videoIn = '0;
		took = 1'b0;
		mode = 0;
		nStrobe = 0;
		evCount = 0;
		outAt = -1;
		void'($urandom(32'h51432B7A));
		do_reset();
		do_line(0, 1'b1, 0, 0);
		line_strobe();
		do_line(0, 1'b1, 1, 0);
		for (int i = 0; i < 8; i++) begin
			line_strobe();
			do_line(i % 4, i < 4, 0, i % 4 == 0 ? 80 : 240);
		end
		do_reset();
		do_line(1, 1'b0, 0, 0);
		give_verdict();
	end
	// About 19000 cycles expected; the limit leaves ample margin
	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		give_verdict();
	end
endmodule : tb_top
